/* hdl/ccg_pkg.sv */
// constants shared by the processor clock, ready and reset generator
package ccg_pkg;
  // ***********************************************************
  // synchronised pin vector layout
  // ***********************************************************
  localparam int PIN_W = 10;
  localparam int PIN_XTAL = 0;
  localparam int PIN_EFI = 1;
  localparam int PIN_SRC_SEL = 2;
  localparam int PIN_CLEAR = 3;
  localparam int PIN_RES_N = 4;
  localparam int PIN_RDY_A = 5;
  localparam int PIN_RDY_B = 6;
  localparam int PIN_QUAL_A_N = 7;
  localparam int PIN_QUAL_B_N = 8;
  localparam int PIN_DEPTH = 9;
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 10'h210;

  // ***********************************************************
  // divider
  // ***********************************************************
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] CNT_LAST = 2'h2;
  localparam logic [CNT_W-1:0] CNT_FIRST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RST_VAL = 2'h2;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam int CTRL_SOFT_CLEAR = 0;
  localparam int CTRL_FORCE_RESET = 1;
  localparam logic [1:0] CTRL_RST_VAL = 2'h0;
endpackage

/* hdl/ccg_top.sv */
// processor clock divider, peripheral clock, reset and ready synchroniser
// Behaviour
// - selected source divided by three, clock high one source period of three
// - peripheral clock toggles each processor clock rise: half rate, 50% duty
// - oscillator buffer output follows the crystal input at its own rate
// - source strap picks crystal or external frequency input for the divider
// - strap high selects external frequency input, low selects crystal
// - oscillator output keeps running whichever source the divider uses
// - counter clear high holds the divider; low lets it resume counting
// - active-low reset request yields active-high processor reset
// - reset request sampled on processor clock falling edge before output
// - two ready inputs, each counted only while its qualifier is active
// - qualifiers are active low
// - two-stage mode: rising ready via stage one on rise, stage two on fall
// - two-stage mode: falling ready clears stage two at the falling edge
// - one-stage mode: stage one bypassed, stage two samples on falling edge
// - depth select honoured anew on every processor clock cycle
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ccg_top #(
  parameter int SYNC_STAGES = 2
) (
  // system
  input wire logic clk_sys,
  input wire logic sys_rst,
  // clock pins
  input wire logic crystal_in,
  input wire logic external_freq_in,
  input wire logic source_select,
  input wire logic counter_clear,
  // reset and ready pins
  input wire logic reset_request_n,
  input wire logic bus_ready_a,
  input wire logic bus_ready_b,
  input wire logic ready_qualifier_a_n,
  input wire logic ready_qualifier_b_n,
  input wire logic sync_depth_select,
  // generated outputs
  output logic cpu_clk,
  output logic peripheral_clk,
  output logic oscillator_buffer_out,
  output logic cpu_reset,
  output logic ready_out,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ccg_pkg::*;

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  assign pin_raw = {sync_depth_select, ready_qualifier_b_n,
                    ready_qualifier_a_n, bus_ready_b, bus_ready_a,
                    reset_request_n, counter_clear, source_select,
                    external_freq_in, crystal_in};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] chain_ff;
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          chain_ff <= {SYNC_STAGES{PIN_RST_VAL[gi]}};
        end else begin
          chain_ff <= {chain_ff[SYNC_STAGES-2:0], pin_raw[gi]};
        end
      end
      assign pin_s[gi] = chain_ff[SYNC_STAGES-1];
    end
  endgenerate

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [1:0] ctrl_ff;
  logic xtal_d_ff;
  logic efi_d_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic cpu_clk_ff;
  logic pclk_ff;
  logic reset_ff;
  logic stage1_ff;
  logic stage2_ff;

  // ***********************************************************
  // source select and divide-by-three
  // ***********************************************************
  logic xtal_edge;
  logic efi_edge;
  logic src_edge;
  logic clear_now;
  logic cpu_rise;
  logic cpu_fall;
  logic [CNT_W-1:0] nxt_cnt;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      xtal_d_ff <= 1'b0;
      efi_d_ff <= 1'b0;
    end else begin
      xtal_d_ff <= pin_s[PIN_XTAL];
      efi_d_ff <= pin_s[PIN_EFI];
    end
  end

  assign xtal_edge = pin_s[PIN_XTAL] & ~xtal_d_ff;
  assign efi_edge = pin_s[PIN_EFI] & ~efi_d_ff;
  // strap high takes the external input
  assign src_edge = pin_s[PIN_SRC_SEL] ? efi_edge : xtal_edge;
  // soft clear lets software align generators without the pin
  assign clear_now = pin_s[PIN_CLEAR] | ctrl_ff[CTRL_SOFT_CLEAR];
  assign cpu_rise = src_edge & ~clear_now & (cnt_ff == CNT_LAST);
  assign cpu_fall = src_edge & ~clear_now & (cnt_ff == CNT_FIRST);

  always_comb begin
    if (cnt_ff == CNT_LAST) begin
      nxt_cnt = CNT_FIRST;
    end else begin
      nxt_cnt = cnt_ff + 2'h1;
    end
  end

  // held at the last count so the first edge after clear raises the clock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_ff <= CNT_RST_VAL;
      cpu_clk_ff <= 1'b0;
    end else if (clear_now) begin
      cnt_ff <= CNT_RST_VAL;
      cpu_clk_ff <= 1'b0;
    end else if (src_edge) begin
      cnt_ff <= nxt_cnt;
      cpu_clk_ff <= (nxt_cnt == CNT_FIRST);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear_now) begin
      pclk_ff <= 1'b0;
    end else if (cpu_rise) begin
      pclk_ff <= ~pclk_ff;
    end
  end

  // ***********************************************************
  // reset logic
  // ***********************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reset_ff <= 1'b1;
    end else if (cpu_fall) begin
      // request sampled only at the processor clock falling edge
      reset_ff <= ~pin_s[PIN_RES_N] | ctrl_ff[CTRL_FORCE_RESET];
    end
  end

  // ***********************************************************
  // ready synchronisation
  // ***********************************************************
  logic qual_ready;
  logic one_stage;
  assign qual_ready = (pin_s[PIN_RDY_A] & ~pin_s[PIN_QUAL_A_N]) |
                      (pin_s[PIN_RDY_B] & ~pin_s[PIN_QUAL_B_N]);
  // sampled per cycle, so each bus cycle may pick its own depth
  assign one_stage = pin_s[PIN_DEPTH];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage1_ff <= 1'b0;
    end else if (cpu_rise) begin
      stage1_ff <= qual_ready;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage2_ff <= 1'b0;
    end else if (cpu_fall) begin
      if (one_stage) begin
        stage2_ff <= qual_ready;
      end else begin
        // a drop goes straight through; a rise must pass stage one
        stage2_ff <= stage1_ff & qual_ready;
      end
    end
  end

  // ***********************************************************
  // apb slave
  // ***********************************************************
  logic apb_access;
  logic hit_ctrl;
  logic hit_status;
  assign apb_access = psel & penable;
  assign hit_ctrl = (paddr == OFS_CTRL);
  assign hit_status = (paddr == OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = apb_access & ~hit_ctrl & ~hit_status;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff <= CTRL_RST_VAL;
    end else if (apb_access && pwrite && hit_ctrl) begin
      ctrl_ff <= pwdata[1:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite && hit_ctrl) begin
      prdata = {30'h0, ctrl_ff};
    end else if (psel && !pwrite && hit_status) begin
      prdata = {22'h0, cnt_ff, pin_s[PIN_SRC_SEL], one_stage, stage1_ff,
                stage2_ff, reset_ff, pclk_ff, cpu_clk_ff,
                pin_s[PIN_XTAL]};
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign cpu_clk = cpu_clk_ff;
  assign peripheral_clk = pclk_ff;
  // crystal buffered regardless of the divider source
  assign oscillator_buffer_out = pin_s[PIN_XTAL];
  assign cpu_reset = reset_ff;
  assign ready_out = stage2_ff;

  // ***********************************************************
  // assertions
  // ***********************************************************
  AST_DIV_HIGH: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_clk_ff && src_edge && !clear_now |=> !cpu_clk_ff)
    else $error("processor clock high longer than one source period");
  AST_DIV_LOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_rise |=> cpu_clk_ff)
    else $error("processor clock did not rise at last count");
  AST_DIV_CNT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cpu_clk_ff |-> (cnt_ff == CNT_FIRST))
    else $error("processor clock high outside count zero");
  AST_PCLK: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(pclk_ff) && !$past(clear_now) |-> $rose(cpu_clk_ff))
    else $error("peripheral clock moved without clock rise");
  AST_OSC: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst, SYNC_STAGES) |->
    (oscillator_buffer_out == $past(crystal_in, SYNC_STAGES)))
    else $error("oscillator output not following crystal");
  AST_SRC: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(cpu_clk_ff) |-> $past(pin_s[PIN_SRC_SEL] ? efi_edge : xtal_edge))
    else $error("divider advanced on wrong source");
  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clear_now |=> !cpu_clk_ff && !pclk_ff && (cnt_ff == CNT_LAST))
    else $error("divider not held by clear");
  AST_RESET_EDGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(reset_ff) |-> $past(cpu_fall))
    else $error("reset changed away from clock fall");
  AST_RESET_POL: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(cpu_fall) && !$past(ctrl_ff[CTRL_FORCE_RESET]) |->
    (reset_ff == !$past(pin_s[PIN_RES_N])))
    else $error("reset polarity wrong");
  AST_RESET_FORCE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(cpu_fall) && $past(ctrl_ff[CTRL_FORCE_RESET]) |-> reset_ff)
    else $error("forced reset not applied at clock fall");
  AST_QUAL_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(cpu_fall) && $past(pin_s[PIN_QUAL_A_N]) &&
    $past(pin_s[PIN_QUAL_B_N]) |-> !ready_out)
    else $error("ready passed with both qualifiers inactive");
  AST_STAGE1: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(stage1_ff) |-> $past(cpu_rise) && $past(qual_ready))
    else $error("stage one captured off clock rise");
  AST_READY_RISE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(ready_out) && !$past(one_stage) |-> $past(cpu_fall) &&
    $past(stage1_ff))
    else $error("two-stage ready rose without stage one");
  AST_READY_FALL: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(ready_out) |-> $past(cpu_fall) && !$past(qual_ready))
    else $error("ready fell without qualified drop");
  AST_ONE_STAGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(cpu_fall) && $past(one_stage) |-> (ready_out == $past(qual_ready)))
    else $error("one-stage ready not sampled at clock fall");
endmodule

`default_nettype wire

/* tb/ccg_far_model.sv */
// far-side model: crystal, external frequency and clear synchroniser
`timescale 1ns/100ps
`default_nettype none
module ccg_far_model #(
  parameter int XTAL_HALF = 4,
  parameter int EFI_HALF = 6
) (
  // clock and request
  input wire logic clk_sys,
  input wire logic clear_req,
  // board signals
  output logic crystal_in,
  output logic external_freq_in,
  output logic counter_clear
);
  int xcnt = 0;
  int ecnt = 0;
  logic clr_meta = 1'b0;
  initial begin
    crystal_in = 1'b0;
    external_freq_in = 1'b0;
    counter_clear = 1'b0;
  end
  // ***********************************************************
  // sources kept below clk_sys/4 so the block can see every edge
  // ***********************************************************
  always @(posedge clk_sys) begin
    xcnt <= (xcnt == XTAL_HALF - 1) ? 0 : xcnt + 1;
    ecnt <= (ecnt == EFI_HALF - 1) ? 0 : ecnt + 1;
    if (xcnt == XTAL_HALF - 1) begin
      crystal_in <= ~crystal_in;
    end
    if (ecnt == EFI_HALF - 1) begin
      external_freq_in <= ~external_freq_in;
    end
  end
  // two flops on the external input keep clear aligned to it
  always @(posedge external_freq_in) begin
    clr_meta <= clear_req;
    counter_clear <= clr_meta;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the clock, reset and ready generator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ccg_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic source_select = 1'b0;
  logic clear_req = 1'b0;
  logic reset_request_n = 1'b1;
  logic bus_ready_a = 1'b0;
  logic bus_ready_b = 1'b0;
  logic ready_qualifier_a_n = 1'b0;
  logic ready_qualifier_b_n = 1'b0;
  logic sync_depth_select = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic crystal_in, external_freq_in, counter_clear, cpu_clk, peripheral_clk;
  logic oscillator_buffer_out, cpu_reset, ready_out, pready, pslverr, err;
  logic [31:0] prdata, rd;
  int mismatches = 0;
  int tests_run = 0;
  int hi, lo, n;
  always #25 clk_sys = ~clk_sys;
  ccg_far_model i_ccg_far_model (.clk_sys, .clear_req, .crystal_in,
    .external_freq_in, .counter_clear);
  ccg_top #(.SYNC_STAGES(2)) i_ccg_top (.clk_sys, .sys_rst, .crystal_in,
    .external_freq_in, .source_select, .counter_clear, .reset_request_n,
    .bus_ready_a, .bus_ready_b, .ready_qualifier_a_n, .ready_qualifier_b_n,
    .sync_depth_select, .cpu_clk, .peripheral_clk, .oscillator_buffer_out,
    .cpu_reset, .ready_out, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return cpu_clk;
      1: return peripheral_clk;
      default: return oscillator_buffer_out;
    endcase
  endfunction
  // sampled on the falling edge so clocked updates have landed
  task automatic wlev(input int s, input logic v, inout int c);
    while (sig(s) !== v) begin
      tick(1);
      c++;
      if (c > 300) begin
        mismatches++;
        finish_test;
      end
    end
  endtask
  task automatic meas(input int s);
    int c;
    c = 0;
    wlev(s, 1'b0, c);
    wlev(s, 1'b1, c);
    c = 0;
    wlev(s, 1'b0, c);
    hi = c;
    c = 0;
    wlev(s, 1'b1, c);
    lo = c;
  endtask
  task automatic wrise;
    int c;
    c = 0;
    wlev(0, 1'b0, c);
    wlev(0, 1'b1, c);
  endtask
  task automatic highs(input int k);
    n = 0;
    repeat (k) begin
      tick(1);
      n += int'(cpu_clk === 1'b1);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int c;
    c = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && c < 50) begin
      @(posedge clk_sys);
      c++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (c >= 50) begin
      mismatches++;
      finish_test;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    tick(1);
    chk(cpu_reset, 1'b1);
    apb(1'b0, OFS_CTRL, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b0, 12'h008, 32'h00000000);
    chk({rd[30:0], err}, 32'h00000001);
    $display("registers test done");
    tick(20);
    meas(0);
    chk(hi, 8);
    chk(hi + lo, 24);
    meas(1);
    chk(hi, 24);
    chk(lo, 24);
    meas(2);
    chk(hi + lo, 8);
    $display("crystal clock test done");
    wrise();
    @(posedge clk_sys);
    reset_request_n <= 1'b0;
    tick(30);
    chk(cpu_reset, 1'b1);
    wrise();
    @(posedge clk_sys);
    reset_request_n <= 1'b1;
    tick(4);
    chk(cpu_reset, 1'b1);
    tick(8);
    chk(cpu_reset, 1'b0);
    $display("reset test done");
    // depth switched between cycles; two-stage first, then one-stage
    for (int d = 0; d < 2; d++) begin
      wrise();
      @(posedge clk_sys);
      sync_depth_select <= d[0];
      bus_ready_a <= 1'b1;
      tick(12);
      chk(ready_out, d[0]);
      tick(24);
      chk(ready_out, 1'b1);
      wrise();
      @(posedge clk_sys);
      bus_ready_a <= 1'b0;
      tick(12);
      chk(ready_out, 1'b0);
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      {bus_ready_a, bus_ready_b, ready_qualifier_a_n, ready_qualifier_b_n} <=
        i[3:0];
      tick(40);
      chk(ready_out, (i[3] & ~i[1]) | (i[2] & ~i[0]));
    end
    $display("ready test done");
    @(posedge clk_sys);
    source_select <= 1'b1;
    tick(40);
    meas(0);
    chk(hi, 12);
    chk(hi + lo, 36);
    meas(2);
    chk(hi + lo, 8);
    apb(1'b0, OFS_STATUS, 32'h00000000);
    chk(rd[7], 1'b1);
    @(posedge clk_sys);
    clear_req <= 1'b1;
    tick(40);
    highs(60);
    chk(n, 0);
    @(posedge clk_sys);
    clear_req <= 1'b0;
    meas(0);
    chk(hi + lo, 36);
    apb(1'b1, OFS_CTRL, 32'h00000001);
    tick(5);
    highs(60);
    chk(n, 0);
    apb(1'b1, OFS_CTRL, 32'h00000002);
    tick(40);
    chk(cpu_reset, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h00000000);
    tick(40);
    chk(cpu_reset, 1'b0);
    $display("external source test done");
    finish_test;
  end
endmodule
`default_nettype wire
